// ===== nwg_pkg.sv
package nwg_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int GUARD_SETUP_INTERVAL_NS = 100;
    localparam int GUARD_SETUP_CYC =
        (GUARD_SETUP_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERUP_WAIT_US = 1000;
    localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000000) / CLK_PERIOD_PS;
    localparam int LOCKED_BLOCK_BUSY_TIME_US = 3;
    localparam int PROTECTED_AREA_BUSY_TIME_US = 30;
    // timeout for a busy phase, covers block erase worst case
    localparam int BUSY_TIMEOUT_US = 10000;
    localparam int BUSY_TIMEOUT_CYC = (BUSY_TIMEOUT_US * 1000) / (CLK_PERIOD_PS / 1000);
    // ------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------
    localparam int STAT_FAIL_BIT = 0;
    localparam int READY_STATUS_BIT = 5;
    localparam int STAT_GUARD_BIT = 7;
    localparam logic [7:0] STAT_READY_GUARD_OFF = 8'he0;
    localparam logic [7:0] STAT_READY_GUARD_ON = 8'h60;
    // ------------------------------------------------------------
    // operation kinds requested by the user side
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NWG_OP_PROG = 3'h0,
        NWG_OP_ERASE = 3'h1,
        NWG_OP_OTP_PROG = 3'h2,
        NWG_OP_OTP_READ = 3'h3,
        NWG_OP_READ = 3'h4
    } nwg_op_e;
    // ------------------------------------------------------------
    // result codes
    // ------------------------------------------------------------
    localparam logic [1:0] RES_OK = 2'h0;
    localparam logic [1:0] RES_FAIL = 2'h1;
    localparam logic [1:0] RES_TIMEOUT = 2'h2;
    localparam logic [1:0] RES_BAD_OP = 2'h3;
endpackage

// ===== nwg_tick_cnt.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// down counter, done pulses when the loaded count expires
// ------------------------------------------------------------
module nwg_tick_cnt #(
    parameter int WIDTH = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    // status
    output logic running,
    output logic done
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;

    initial begin
        if (WIDTH < 2) $error("nwg_tick_cnt: WIDTH too small");
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = load_val;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign running = (cnt_ff != '0);
    assign done = (cnt_ff == WIDTH'(1));
endmodule

// ===== nwg_host.sv
`timescale 1ns/1ps
module nwg_host
    import nwg_pkg::*;
#(
    parameter int POWERUP_CYC = POWERUP_WAIT_CYC,
    parameter int TIMEOUT_CYC = BUSY_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [2:0] req_op,
    input wire logic req_guard_off,
    // user result
    output logic res_valid,
    output logic [1:0] res_code,
    output logic [7:0] res_status,
    output logic powered_up,
    // device side
    output logic guard_n,
    output logic cmd_strobe,
    output logic [2:0] cmd_op,
    input wire logic ready_busy_n,
    output logic status_strobe,
    input wire logic [7:0] status_byte
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        NWG_POWERUP = 7'h01,
        NWG_IDLE = 7'h02,
        NWG_SETUP = 7'h04,
        NWG_ISSUE = 7'h08,
        NWG_WAIT = 7'h10,
        NWG_STATUS = 7'h20,
        NWG_DONE = 7'h40
    } nwg_state_e;

    localparam int CW = $clog2(POWERUP_CYC + TIMEOUT_CYC + 2) + 1;

    nwg_state_e state_ff, nxt_state;
    logic guard_n_ff, nxt_guard_n;
    logic [2:0] op_ff, nxt_op;
    logic [1:0] code_ff, nxt_code;
    logic [7:0] stat_ff, nxt_stat;
    logic pwr_ff, nxt_pwr;
    logic cnt_load;
    logic [CW-1:0] cnt_val;
    logic cnt_run;
    logic cnt_done;
    logic boot_ff;

    initial begin
        if (POWERUP_CYC < 1 || TIMEOUT_CYC < 1) $error("nwg_host: counts must be positive");
    end

    nwg_tick_cnt #(.WIDTH(CW)) u_cnt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(cnt_load),
        .load_val(cnt_val),
        .running(cnt_run),
        .done(cnt_done)
    );

    function automatic logic is_write_op(input logic [2:0] op);
        return op == NWG_OP_PROG || op == NWG_OP_ERASE || op == NWG_OP_OTP_PROG;
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_guard_n = guard_n_ff;
        nxt_op = op_ff;
        nxt_code = code_ff;
        nxt_stat = stat_ff;
        nxt_pwr = pwr_ff;
        cnt_load = 1'b0;
        cnt_val = '0;
        unique case (state_ff)
            NWG_POWERUP: begin
                // guard stays low until the power-up wait expires
                nxt_guard_n = 1'b0;
                // first cycle out of reset arms the wait, nothing else reloads it here
                if (boot_ff) begin
                    cnt_load = 1'b1;
                    cnt_val = CW'(POWERUP_CYC);
                end
                if (cnt_done) begin
                    nxt_pwr = 1'b1;
                    nxt_state = NWG_IDLE;
                end
            end
            NWG_IDLE: begin
                // a still-busy device must not see the guard move
                if (req_valid && ready_busy_n) begin
                    nxt_op = req_op;
                    // only program, erase and otp program may lift the guard
                    nxt_guard_n = req_guard_off && is_write_op(req_op);
                    cnt_load = 1'b1;
                    cnt_val = CW'(GUARD_SETUP_CYC + 1);
                    nxt_state = NWG_SETUP;
                end
            end
            NWG_SETUP: begin
                if (cnt_done) begin
                    nxt_state = NWG_ISSUE;
                end
            end
            NWG_ISSUE: begin
                // otp ops travel as their own command codes, never as plain ones
                cnt_load = 1'b1;
                cnt_val = CW'(TIMEOUT_CYC + 1);
                nxt_state = NWG_WAIT;
            end
            NWG_WAIT: begin
                // a device that never leaves busy is reported, not waited on forever
                if (ready_busy_n && !cnt_run) begin
                    nxt_state = NWG_STATUS;
                end else if (ready_busy_n && cnt_run) begin
                    nxt_state = NWG_STATUS;
                end else if (cnt_done) begin
                    nxt_code = RES_TIMEOUT;
                    nxt_stat = status_byte;
                    nxt_state = NWG_DONE;
                end
            end
            NWG_STATUS: begin
                nxt_stat = status_byte;
                if (!status_byte[READY_STATUS_BIT]) begin
                    nxt_code = RES_TIMEOUT;
                end else if (status_byte[STAT_FAIL_BIT]) begin
                    nxt_code = RES_FAIL;
                end else begin
                    nxt_code = RES_OK;
                end
                nxt_state = NWG_DONE;
            end
            NWG_DONE: begin
                nxt_guard_n = 1'b0;
                nxt_state = NWG_IDLE;
            end
            default: begin
                nxt_state = NWG_IDLE;
            end
        endcase
        if (state_ff == NWG_IDLE && req_valid && ready_busy_n && req_op > NWG_OP_READ) begin
            nxt_code = RES_BAD_OP;
            nxt_state = NWG_DONE;
            cnt_load = 1'b0;
            nxt_guard_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= NWG_POWERUP;
            guard_n_ff <= 1'b0;
            op_ff <= 3'h0;
            code_ff <= RES_OK;
            stat_ff <= 8'h00;
            pwr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            guard_n_ff <= nxt_guard_n;
            op_ff <= nxt_op;
            code_ff <= nxt_code;
            stat_ff <= nxt_stat;
            pwr_ff <= nxt_pwr;
        end
    end

    // powerup count loaded once on the first cycle after reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_ff <= 1'b1;
        end else begin
            boot_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready = (state_ff == NWG_IDLE) && ready_busy_n;
    assign guard_n = guard_n_ff;
    assign cmd_strobe = (state_ff == NWG_ISSUE);
    assign cmd_op = op_ff;
    assign status_strobe = (state_ff == NWG_STATUS);
    assign res_valid = (state_ff == NWG_DONE);
    assign res_code = code_ff;
    assign res_status = stat_ff;
    assign powered_up = pwr_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_guard_stable;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_ff == NWG_WAIT) |-> $stable(guard_n);
    endproperty
    a_guard_stable: assert property (p_guard_stable) else $error("guard moved in busy");

    property p_setup;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(cmd_strobe) |-> $past(guard_n, 4) == guard_n;
    endproperty
    a_setup: assert property (p_setup) else $error("guard setup violated");

    property p_no_cmd_powerup;
        @(posedge clk_sys) disable iff (!rst_n)
        !powered_up |-> !cmd_strobe && !guard_n;
    endproperty
    a_no_cmd_powerup: assert property (p_no_cmd_powerup) else $error("cmd before power-up");

    property p_read_guarded;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_strobe && !is_write_op(cmd_op) |-> !guard_n;
    endproperty
    a_read_guarded: assert property (p_read_guarded) else $error("guard lifted for read");

    property p_fail_flag;
        @(posedge clk_sys) disable iff (!rst_n)
        status_strobe && status_byte[READY_STATUS_BIT] && status_byte[STAT_FAIL_BIT]
            |=> res_valid && res_code == RES_FAIL;
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("failure not reported");

    property p_ready_bit;
        @(posedge clk_sys) disable iff (!rst_n)
        status_strobe && !status_byte[READY_STATUS_BIT] |=> res_code != RES_OK;
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("busy status taken as ok");

    property p_guard_rest;
        @(posedge clk_sys) disable iff (!rst_n)
        res_valid |=> !guard_n;
    endproperty
    a_guard_rest: assert property (p_guard_rest) else $error("guard left open");

    property p_issue_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_strobe |=> state_ff == NWG_WAIT;
    endproperty
    a_issue_wait: assert property (p_issue_wait) else $error("no busy wait after issue");

    c_write: cover property (@(posedge clk_sys) cmd_strobe && is_write_op(cmd_op) && guard_n);
    c_fail: cover property (@(posedge clk_sys) res_valid && res_code == RES_FAIL);
    c_otp: cover property (@(posedge clk_sys) cmd_strobe && cmd_op == NWG_OP_OTP_PROG);
endmodule

// ===== nwg_dev_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// behavioural device: guard, block lock, one-time area, status
// ------------------------------------------------------------
module nwg_dev_model
    import nwg_pkg::*;
#(
    parameter int BUSY_CYC = 20,
    parameter int LOCK_BUSY_CYC = 10,
    parameter int OTP_BUSY_CYC = 30,
    parameter int OTP_PAGE_BYTES = 2112
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // host pins
    input wire logic guard_n,
    input wire logic cmd_strobe,
    input wire logic [2:0] cmd_op,
    output logic ready_busy_n,
    input wire logic status_strobe,
    output logic [7:0] status_byte,
    // scenario controls
    input wire logic lock_all,
    input wire logic otp_locked,
    input wire logic stuck_busy
);
    int busy_cnt;
    logic fail_ff;
    logic otp_blank_ff;
    logic blocked;
    always_comb begin
        blocked = 1'b0;
        if (cmd_op <= 3'h2 && !guard_n) blocked = 1'b1;
        if (cmd_op <= 3'h1 && lock_all) blocked = 1'b1;
        if (cmd_op == 3'h2 && otp_locked) blocked = 1'b1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 0;
            fail_ff <= 1'b0;
            otp_blank_ff <= 1'b1;
        end else if (cmd_strobe) begin
            fail_ff <= blocked;
            // no erase path: only an accepted otp program clears it
            if (cmd_op == 3'h2 && !blocked) otp_blank_ff <= 1'b0;
            if (cmd_op == 3'h2 && otp_locked) busy_cnt <= OTP_BUSY_CYC;
            else if (blocked) busy_cnt <= LOCK_BUSY_CYC;
            else busy_cnt <= BUSY_CYC;
        end else if (busy_cnt > 0 && !stuck_busy) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    assign ready_busy_n = (busy_cnt == 0);
    assign status_byte = {guard_n, 1'b1, ready_busy_n, 4'h0, fail_ff};
endmodule

// ===== nwg_host_tb.sv
`timescale 1ns/1ps
module nwg_host_tb import nwg_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0, req_ready, req_guard_off = 1'b0;
    logic [2:0] req_op = 3'h0, cmd_op;
    logic res_valid, powered_up, guard_n, cmd_strobe, ready_busy_n, status_strobe;
    logic [1:0] res_code;
    logic [7:0] res_status, status_byte;
    logic lock_all = 1'b0, otp_locked = 1'b0, stuck_busy = 1'b0;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    localparam int TB_PWR_CYC = 4;
    nwg_host #(.POWERUP_CYC(TB_PWR_CYC), .TIMEOUT_CYC(50)) u_nwg_host (.clk_sys(clk_sys),
        .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_guard_off(req_guard_off), .res_valid(res_valid), .res_code(res_code),
        .res_status(res_status), .powered_up(powered_up), .guard_n(guard_n),
        .cmd_strobe(cmd_strobe), .cmd_op(cmd_op), .ready_busy_n(ready_busy_n),
        .status_strobe(status_strobe), .status_byte(status_byte));
    nwg_dev_model u_nwg_dev_model (.clk_sys(clk_sys), .rst_n(rst_n), .guard_n(guard_n),
        .cmd_strobe(cmd_strobe), .cmd_op(cmd_op), .ready_busy_n(ready_busy_n),
        .status_strobe(status_strobe), .status_byte(status_byte), .lock_all(lock_all),
        .otp_locked(otp_locked), .stuck_busy(stuck_busy));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // one request; exp_stat of zero skips the status compare
    // ------------------------------------------------------------
    task automatic run_op(input logic [2:0] op, input logic goff, input logic [1:0] exp_code,
        input logic [7:0] exp_stat);
        int n;
        int setup;
        logic issued;
        logic steady;
        logic g;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_op = op;
        req_guard_off = goff;
        n = 0;
        do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 100);
        @(negedge clk_sys);
        req_valid = 1'b0;
        setup = 0;
        issued = 1'b0;
        steady = 1'b1;
        g = 1'b0;
        for (n = 0; n < 500 && res_valid !== 1'b1; n++) begin
            if (cmd_strobe === 1'b1) begin
                issued = 1'b1;
                g = guard_n;
            end else if (!issued && guard_n === 1'b1) setup++;
            else if (issued && guard_n !== g && ready_busy_n !== 1'b1) steady = 1'b0;
            @(negedge clk_sys);
        end
        chk({7'h0, res_valid}, 8'h01);
        chk({6'h0, res_code}, {6'h0, exp_code});
        chk({7'h0, issued}, {7'h0, exp_code != RES_BAD_OP});
        chk({7'h0, g}, {7'h0, goff && op <= 3'h2 && issued});
        if (g) chk({7'h0, setup >= GUARD_SETUP_CYC}, 8'h01);
        chk({7'h0, steady}, 8'h01);
        if (exp_stat != 8'h00) chk(res_status, exp_stat);
        for (n = 0; n < 500 && ready_busy_n !== 1'b1; n++) @(negedge clk_sys);
    endtask
    task automatic t_powerup();
        int n;
        chk({7'h0, guard_n}, 8'h00);
        @(negedge clk_sys);
        rst_n = 1'b1;
        for (n = 0; n < 100 && powered_up !== 1'b1; n++) @(negedge clk_sys);
        chk({7'h0, powered_up}, 8'h01);
        chk({7'h0, n >= TB_PWR_CYC}, 8'h01);
        chk({7'h0, u_nwg_dev_model.otp_blank_ff}, 8'h01);
    endtask
    task automatic t_enabled();
        run_op(3'h0, 1'b1, RES_OK, STAT_READY_GUARD_OFF);
        run_op(3'h1, 1'b1, RES_OK, STAT_READY_GUARD_OFF);
        run_op(3'h4, 1'b1, RES_OK, STAT_READY_GUARD_ON);
    endtask
    task automatic t_guarded();
        run_op(3'h0, 1'b0, RES_FAIL, STAT_READY_GUARD_ON | 8'h01);
        run_op(3'h1, 1'b0, RES_FAIL, STAT_READY_GUARD_ON | 8'h01);
    endtask
    task automatic t_lock();
        lock_all = 1'b1;
        run_op(3'h0, 1'b1, RES_FAIL, STAT_READY_GUARD_OFF | 8'h01);
        run_op(3'h1, 1'b1, RES_FAIL, STAT_READY_GUARD_OFF | 8'h01);
        lock_all = 1'b0;
    endtask
    task automatic t_otp();
        run_op(3'h2, 1'b1, RES_OK, STAT_READY_GUARD_OFF);
        chk({7'h0, u_nwg_dev_model.otp_blank_ff}, 8'h00);
        otp_locked = 1'b1;
        run_op(3'h2, 1'b1, RES_FAIL, STAT_READY_GUARD_OFF | 8'h01);
        run_op(3'h3, 1'b1, RES_OK, STAT_READY_GUARD_ON);
        otp_locked = 1'b0;
    endtask
    task automatic t_bad_and_timeout();
        run_op(3'h5, 1'b1, RES_BAD_OP, 8'h00);
        run_op(3'h7, 1'b0, RES_BAD_OP, 8'h00);
        stuck_busy = 1'b1;
        run_op(3'h0, 1'b1, RES_TIMEOUT, STAT_READY_GUARD_OFF & 8'hdf);
        stuck_busy = 1'b0;
        run_op(3'h1, 1'b1, RES_OK, STAT_READY_GUARD_OFF);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        t_powerup();
        t_enabled();
        t_guarded();
        t_lock();
        t_otp();
        t_bad_and_timeout();
        end_sim();
    end
endmodule
